// *** rtl/adc_port_pkg.sv ***
// Constants, register map and carrier types for the converter serial port.
`default_nettype none
package adc_port_pkg;

	// ==========================================================
	// Frame shape
	localparam int NUM_CH = 8;
	localparam int CODE_BITS = 12;
	localparam int CTRL_BITS = 8;
	localparam int FRAME_BITS = 16;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [4:0] CTRL_LAST_EDGE = 5'h07;
	localparam logic [4:0] FRAME_LAST_EDGE = 5'h0F;
	localparam logic [4:0] FRAME_DONE = 5'h10;
	localparam logic [3:0] OUT_LAST = 4'hF;
	localparam logic [3:0] OUT_TOP = 4'hE;

	// ==========================================================
	// Register map, byte addresses on the Avalon slave
	localparam logic [7:0] CODE_BASE = 8'h00;
	localparam logic [7:0] CODE_END = 8'h20;
	localparam logic [7:0] STATUS_OFS = 8'h20;
	localparam int STAT_ACTIVE_BIT = 8;
	localparam int STAT_COUNT_LSB = 16;
	localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ==========================================================
	// Control byte, first bit on the wire is the top bit
	typedef struct packed {
		logic ignored_bit;
		logic zero_bit;
		logic [2:0] channel_addr;
		logic ref_disable;
		logic [1:0] power_mode;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = 8'h00;

	typedef logic [CODE_BITS-1:0] code_t;

endpackage
`default_nettype wire

// *** rtl/adc_serial_conversion_port.sv ***
// Serial control and result port of an eight-input 12-bit converter, with Avalon access.
// Summary of operation
// R1: Frame select is active low; the port reacts to shift clock only while low.
// R2: Frame select falling opens the serial frame; the conversion starts on the first rising shift-clock edge.
// R3: Control input is sampled on the first seven rising shift-clock edges into the shift register; the eighth bit goes straight to the control byte.
// R4: Result output changes on each of the first fifteen falling shift-clock edges.
// R5: Result word is four zeros then the 12-bit code, top bit first.
// R6: A three-bit address in the control byte picks one of eight inputs.
// R7: All conversion timing comes from the shift clock; no own oscillator.
// R8: At conversion end the sampling stage returns to tracking the input.
// R9: Only the first eight rising edges of a frame load the control byte.
// R10: Host supplies sixteen shift-clock cycles per frame.
// R11: A new channel address takes effect at the end of the current conversion.
// R12: Control byte top bit first: ignored, zero, address, reference off, power mode.
// R13: Result output is off while frame select is high, enabled soon after it falls; here the enable follows both edges two to three register-clock cycles late.
// R14: First result bit stands before first falling edge; then one bit per falling edge.
`default_nettype none
module adc_serial_conversion_port
	import adc_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	output logic tracking,
	output logic [2:0] channel_select,
	output logic ref_disable,
	output logic [1:0] power_mode
);

	// ==========================================================
	// Decode helpers
	function automatic logic is_code(input logic [7:0] a);
		is_code = (a >= CODE_BASE) && (a < CODE_END);
	endfunction

	// Word index inside the code window
	function automatic logic [2:0] code_index(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - CODE_BASE;
		code_index = rel[4:2];
	endfunction

	// ==========================================================
	// Reset release on the register clock
	logic rst_q1_reg;
	logic rst_n_reg;

	// Async assert, two-stage release
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_q1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_n_reg <= rst_q1_reg;
		end
	end

	// Link-side release; the shift clock may stop, so assertion stays async
	logic link_q1_reg;
	logic link_rst_n_reg;

	always_ff @(posedge sclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			link_q1_reg <= 1'b0;
			link_rst_n_reg <= 1'b0;
		end else begin
			link_q1_reg <= 1'b1;
			link_rst_n_reg <= link_q1_reg;
		end
	end

	// ==========================================================
	// Register side: per-channel codes standing in for the analog inputs
	code_t code_reg [NUM_CH];
	logic bus_write;
	logic bus_read_take;

	assign bus_write = avs_write && !avs_waitrequest;
	assign bus_read_take = avs_read && avs_waitrequest;

	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_code
			// Byte lanes 0 and 1 carry the 12-bit code
			always_ff @(posedge ref_clk or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					code_reg[ch] <= CODE_RESET;
				end else if (bus_write && is_code(avs_address)
					&& code_index(avs_address) == 3'(ch)) begin
					if (avs_byteenable[0]) begin
						code_reg[ch][7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						code_reg[ch][CODE_BITS-1:8] <= avs_writedata[CODE_BITS-1:8];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Code table crossing to the link by request/acknowledge toggles
	code_t shadow_reg [NUM_CH];
	logic req_tgl_reg;
	logic ack_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;

	// Acknowledge toggle brought back into the register clock
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
		end
	end

	// Shadow only moves once the link has taken the previous copy
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			req_tgl_reg <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				shadow_reg[i] <= CODE_RESET;
			end
		end else if (ack_s2_reg == req_tgl_reg) begin
			req_tgl_reg <= ~req_tgl_reg;
			for (int i = 0; i < NUM_CH; i++) begin
				shadow_reg[i] <= code_reg[i];
			end
		end
	end

	// ==========================================================
	// Link side: code copy, refreshed only while the shift clock runs
	code_t link_code_reg [NUM_CH];
	logic req_s1_reg;
	logic req_s2_reg;

	// Request toggle brought into the shift-clock domain
	always_ff @(posedge sclk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
		end
	end

	// Shadow is held stable while the request is open
	always_ff @(posedge sclk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			ack_tgl_reg <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				link_code_reg[i] <= CODE_RESET;
			end
		end else if (req_s2_reg != ack_tgl_reg) begin
			ack_tgl_reg <= req_s2_reg;
			for (int i = 0; i < NUM_CH; i++) begin
				link_code_reg[i] <= shadow_reg[i];
			end
		end
	end

	// ==========================================================
	// Frame sequencing on rising shift-clock edges
	logic [4:0] bit_cnt_reg;
	logic [CTRL_BITS-2:0] shift_in_reg;
	code_t result_reg;
	ctrl_s ctrl_reg;
	logic [2:0] chan_active_reg;
	logic ctrl_tgl_reg;

	// Frame select high clears the frame, so no edge outside a frame counts
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= 5'h00; // R1
			shift_in_reg <= '0;
			tracking <= 1'b1;
			result_reg <= CODE_RESET;
		end else begin
			if (bit_cnt_reg != FRAME_DONE) begin
				bit_cnt_reg <= bit_cnt_reg + 5'h01; // R7
			end
			if (bit_cnt_reg < CTRL_LAST_EDGE) begin
				shift_in_reg <= {shift_in_reg[CTRL_BITS-3:0], din}; // R3
			end
			if (bit_cnt_reg == 5'h00) begin
				result_reg <= link_code_reg[chan_active_reg]; // R2 R6
			end
			// Hold during conversion, track again after the sixteenth edge
			tracking <= (bit_cnt_reg >= FRAME_LAST_EDGE); // R8
		end
	end

	// Control byte survives frames; only the first eight bits load it
	always_ff @(posedge sclk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			ctrl_reg <= CTRL_RESET; // R12
			ctrl_tgl_reg <= 1'b0;
		end else if (bit_cnt_reg == CTRL_LAST_EDGE) begin
			ctrl_reg <= {shift_in_reg, din}; // R9 R12
			ctrl_tgl_reg <= ~ctrl_tgl_reg;
		end
	end

	// New address is applied only when the conversion ends
	always_ff @(posedge sclk or negedge link_rst_n_reg) begin
		if (!link_rst_n_reg) begin
			chan_active_reg <= 3'h0;
			channel_select <= 3'h0;
			ref_disable <= 1'b0;
			power_mode <= 2'h0;
		end else if (bit_cnt_reg == FRAME_LAST_EDGE) begin
			chan_active_reg <= ctrl_reg.channel_addr; // R11 R6
			channel_select <= ctrl_reg.channel_addr;
			ref_disable <= ctrl_reg.ref_disable;
			power_mode <= ctrl_reg.power_mode;
		end
	end

	// ==========================================================
	// Result shifting on falling shift-clock edges
	logic [3:0] out_cnt_reg;
	logic [FRAME_BITS-1:0] out_word;

	assign out_word = {LEAD_ZEROS, result_reg}; // R5

	// Top bit is a leading zero, so the cleared value already presents it
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			dout <= 1'b0; // R14
			out_cnt_reg <= 4'h0;
		end else if (out_cnt_reg != OUT_LAST) begin
			dout <= out_word[OUT_TOP - out_cnt_reg]; // R4 R14
			out_cnt_reg <= out_cnt_reg + 4'h1;
		end
	end

	// ==========================================================
	// Frame select seen from the register clock
	logic cs_s1_reg;
	logic cs_s2_reg;

	// Two flops, as frame select has no relation to this clock
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
		end
	end

	// Enable lags frame select by the synchroniser, two to three register-clock cycles
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dout_oe_n <= 1'b1;
		end else begin
			dout_oe_n <= cs_s2_reg; // R13
		end
	end

	// ==========================================================
	// Control byte reported back; it is stable long after its toggle
	logic ctl_s1_reg;
	logic ctl_s2_reg;
	logic ctl_s3_reg;
	ctrl_s ctrl_seen_reg;
	logic [15:0] frame_count_reg;

	// Third stage gives the edge of the load toggle
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctl_s1_reg <= 1'b0;
			ctl_s2_reg <= 1'b0;
			ctl_s3_reg <= 1'b0;
		end else begin
			ctl_s1_reg <= ctrl_tgl_reg;
			ctl_s2_reg <= ctl_s1_reg;
			ctl_s3_reg <= ctl_s2_reg;
		end
	end

	// Copy and count once per loaded control byte
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_seen_reg <= CTRL_RESET;
			frame_count_reg <= 16'h0000;
		end else if (ctl_s2_reg != ctl_s3_reg) begin
			ctrl_seen_reg <= ctrl_reg;
			frame_count_reg <= frame_count_reg + 16'h0001;
		end
	end

	// ==========================================================
	// Avalon slave: one wait cycle, then answer
	// Read decode; bits above a code or a status field read as zero
	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] v;
		v = UNMAPPED_READ;
		if (is_code(a)) begin
			v[CODE_BITS-1:0] = code_reg[code_index(a)];
		end else if (a == STATUS_OFS) begin
			v[CTRL_BITS-1:0] = ctrl_seen_reg;
			v[STAT_ACTIVE_BIT] = !cs_s2_reg;
			v[STAT_COUNT_LSB +: 16] = frame_count_reg;
		end
		read_mux = v;
	endfunction

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge ref_clk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
			if (bus_read_take) begin
				avs_readdata <= read_mux(avs_address);
			end
		end
	end

endmodule
`default_nettype wire

// *** verif/adc_port_chk.sv ***
// Concurrent checks on the converter port pins and its Avalon slave.
`default_nettype none
module adc_port_chk
	import adc_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic cs_n,
	input wire logic dout,
	input wire logic dout_oe_n,
	input wire logic tracking,
	input wire logic [2:0] channel_select,
	input wire logic ref_disable,
	input wire logic [1:0] power_mode
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Pin and bus relations, all seen from the register clock
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_dout_idle_low: assert property (cs_n |-> !dout)
		else $error("dout not low while deselected");
	a_oe_off_idle: assert property (cs_n [*4] |-> dout_oe_n)
		else $error("dout enabled while deselected");
	a_oe_on_frame: assert property (!cs_n [*4] |-> !dout_oe_n)
		else $error("dout not enabled in frame");
	a_track_idle: assert property (cs_n |-> tracking)
		else $error("not tracking between frames");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered next cycle");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("answer without request");
	// Address and mode move only when the conversion ends
	a_ctrl_at_end: assert property (($changed(channel_select) || $changed(ref_disable)
		|| $changed(power_mode)) |-> $rose(tracking))
		else $error("control applied outside frame end");

	c_frame: cover property ($fell(cs_n));
	c_new_chan: cover property ($changed(channel_select));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind adc_serial_conversion_port adc_port_chk adc_port_chk_inst (.ref_clk, .reset_n, .avs_read,
	.avs_write, .avs_waitrequest, .cs_n, .dout, .dout_oe_n, .tracking, .channel_select,
	.ref_disable, .power_mode);
`default_nettype wire

// *** verif/adc_serial_conversion_port_tb.sv ***
// Self-checking bench for the converter serial port and its register access.
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, s); end end
module adc_serial_conversion_port_tb
	import adc_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk = 1'b0;
	logic reset_n, avs_read, avs_write, avs_waitrequest, sclk, cs_n, din, dout;
	logic dout_oe_n, tracking, ref_disable;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [2:0] channel_select;
	logic [1:0] power_mode;
	int failures = 0;
	int checks = 0;
	code_t codes [NUM_CH];

	// 20 MHz register clock
	always #25 ref_clk = ~ref_clk;

	adc_serial_conversion_port adc_serial_conversion_port_inst (.ref_clk, .reset_n, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.sclk, .cs_n, .din, .dout, .dout_oe_n, .tracking, .channel_select, .ref_disable,
		.power_mode);
	host_master host_inst (.sclk, .cs_n, .din, .dout, .dout_oe_n);

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One Avalon cycle; held until waitrequest is seen low, bounded
	task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 16);
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			report_and_stop();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] q;
		av(1'b0, CODE_BASE, 32'h0, q);
		`CHK("code reset", {20'h00000, CODE_RESET}, q)
		for (int ch = 0; ch < NUM_CH; ch++) begin
			codes[ch] = code_t'(ch * 547 + 123);
			av(1'b1, CODE_BASE + 8'(ch * 4), {20'hFFFFF, codes[ch]}, q);
		end
		for (int ch = 0; ch < NUM_CH; ch++) begin
			av(1'b0, CODE_BASE + 8'(ch * 4), 32'h0, q);
			`CHK("code", {20'h00000, codes[ch]}, q)
		end
		// Lane 0 only: the top four code bits must keep their value
		avs_byteenable <= 4'h1;
		av(1'b1, CODE_BASE, 32'h0000_0FFF, q);
		avs_byteenable <= 4'hF;
		av(1'b0, CODE_BASE, 32'h0, q);
		`CHK("lane zero", {20'h00000, codes[0][11:8], 8'hFF}, q)
		av(1'b1, CODE_BASE, {20'h00000, codes[0]}, q);
		av(1'b0, CODE_BASE, 32'h0, q);
		`CHK("lane restore", {20'h00000, codes[0]}, q)
		av(1'b1, STATUS_OFS, 32'hFFFF_FFFF, q);
		av(1'b0, STATUS_OFS, 32'h0, q);
		`CHK("status reset", 32'h0000_0000, q)
		av(1'b0, CODE_END + 8'h04, 32'h0, q);
		`CHK("unmapped", UNMAPPED_READ, q)
		$display("test regs done");
	endtask

	// Each frame returns the code chosen by the previous frame's address
	task automatic t_frames();
		logic [15:0] r;
		logic [31:0] q;
		logic [7:0] c;
		logic [2:0] ch;
		logic [2:0] prev;
		prev = 3'h0;
		repeat (3) host_inst.xfer(8'h00, 16, r);
		for (int k = 0; k < 9; k++) begin
			ch = 3'(k * 5);
			c = {~k[0], 1'b0, ch, k[1], k[2:1]};
			host_inst.xfer(c, 16, r);
			`CHK("lead zeros", LEAD_ZEROS, r[15:12])
			`CHK("result", codes[prev], r[11:0])
			`CHK("channel", c[5:3], channel_select)
			`CHK("ref pm", c[2:0], {ref_disable, power_mode})
			av(1'b0, STATUS_OFS, 32'h0, q);
			`CHK("ctrl byte", c, q[7:0])
			prev = ch;
		end
		$display("test frames done");
	endtask

	// Short frames: six clocks load nothing, eight load the byte only
	task automatic t_short();
		logic [15:0] r;
		logic [31:0] q0;
		logic [31:0] q1;
		logic [2:0] ch0;
		ch0 = channel_select;
		av(1'b0, STATUS_OFS, 32'h0, q0);
		host_inst.xfer(8'h28, 6, r);
		av(1'b0, STATUS_OFS, 32'h0, q1);
		`CHK("status short", q0, q1)
		host_inst.xfer(8'h28, 8, r);
		av(1'b0, STATUS_OFS, 32'h0, q1);
		`CHK("ctrl eight", 8'h28, q1[7:0])
		`CHK("frame count", q0[31:16] + 16'h0001, q1[31:16])
		`CHK("channel kept", ch0, channel_select)
		$display("test short done");
	endtask

	// Reset for two cycles, then the scenarios
	initial begin
		reset_n = 1'b0;
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_frames();
		t_short();
		report_and_stop();
	end
endmodule
`default_nettype wire

// *** verif/host_master.sv ***
// Behavioural serial host that frames transfers to the converter port.
`default_nettype none
module host_master (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	// Shift clock idles low and stands still between frames
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		din = 1'b0;
		// A real rising edge once the design runs clears its frame logic
		#1 cs_n = 1'b1;
	end

	// One frame of n clocks at 48 ns; a bit seen while undriven reads unknown
	task automatic xfer(input logic [7:0] c, input int n, output logic [15:0] r);
		r = 16'h0000;
		// Keeps frame select off the register clock's edge
		#5;
		cs_n = 1'b0;
		#163;
		for (int i = 0; i < n; i++) begin
			din = (i < 8) ? c[7 - i] : ~din;
			#24 sclk = 1'b1;
			r = {r[14:0], dout_oe_n ? 1'bx : dout};
			#24 sclk = 1'b0;
		end
		#24 cs_n = 1'b1;
		din = ~din;
		#170;
	endtask
endmodule
`default_nettype wire
